/* File: verilog/vfd_cfg.svh */
/*
  constants of the field detection front end: register offset, bit positions,
  reset values and timing counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef VFD_CFG_SVH
`define VFD_CFG_SVH

`define VFD_REG_INIT_OFFSET  8'h00
`define VFD_BIT_MODE_LO      0
`define VFD_BIT_MODE_HI      1
`define VFD_BIT_VEDGE        2
`define VFD_BIT_HPOL         3
`define VFD_BIT_VKIND        4
`define VFD_BIT_REGSET_FIX   5
`define VFD_BIT_REGSET_INV   6
`define VFD_INIT_RESET       8'h00
`define VFD_FREE_LINES       16'h0139
`define VFD_NOISE_TOL        16'h0004
`define VFD_FREERUN_SET      20'h003e7

`endif

/* File: verilog/vfd_pkg.sv */
/*
  types of the field detection front end.
  assumes nothing beyond a systemverilog compiler.
*/
package vfd_pkg;
  typedef enum logic [1:0] {
    VFD_MODE_DIRECT,
    VFD_MODE_NOISE,
    VFD_MODE_FREE,
    VFD_MODE_RSVD
  } vfd_mode_t;

  typedef enum logic [1:0] {
    VFD_ST_IDLE,
    VFD_ST_TRACK,
    VFD_ST_FREE
  } vfd_state_t;
endpackage

/* File: verilog/vfd_cfg_if.sv */
/*
  carrier of the decoded configuration between the register file and the core.
  assumes the register file drives it and the core only reads it.
*/
`timescale 1ns/100ps
`default_nettype none
interface vfd_cfg_if;
  vfd_pkg::vfd_mode_t mode;
  logic               vedge_fall;
  logic               hpol_high;
  logic               vkind_frame;
  logic               regset_fix;
  logic               regset_inv;
  modport regs (output mode, vedge_fall, hpol_high, vkind_frame, regset_fix, regset_inv);
  modport core (input mode, vedge_fall, hpol_high, vkind_frame, regset_fix, regset_inv);
endinterface
`default_nettype wire

/* File: verilog/vfd_regs.sv */
/*
  holds the initial settings register at subaddress 00h.
  assumes a decoded write strobe and byte address from the control bus slave.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vfd_cfg.svh"
module vfd_regs (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // register access
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // decoded settings
  vfd_cfg_if.regs         cfg
);
  logic [7:0] init_q;
  logic [7:0] init_d;

  always_comb begin
    init_d = init_q;
    if (wr_en && wr_addr == `VFD_REG_INIT_OFFSET) begin
      init_d = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      init_q <= `VFD_INIT_RESET;
    end else begin
      init_q <= init_d;
    end
  end

  assign rd_data         = init_q;
  assign cfg.mode        = vfd_pkg::vfd_mode_t'({init_q[`VFD_BIT_MODE_HI], init_q[`VFD_BIT_MODE_LO]});
  assign cfg.vedge_fall  = init_q[`VFD_BIT_VEDGE];
  assign cfg.hpol_high   = init_q[`VFD_BIT_HPOL];
  assign cfg.vkind_frame = init_q[`VFD_BIT_VKIND];
  assign cfg.regset_fix  = init_q[`VFD_BIT_REGSET_FIX];
  assign cfg.regset_inv  = init_q[`VFD_BIT_REGSET_INV];

  a_reset_clears: assert property (@(posedge sys_clk) $rose(rstn) |-> init_q == `VFD_INIT_RESET)
    else $error("settings not cleared by reset");
endmodule
`default_nettype wire

/* File: verilog/vfd_top.sv */
/*
  field detection front end: derives the odd/even field from h and v sync.
  assumes syncs synchronous to sys_clk and a control bus slave giving byte writes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vfd_cfg.svh"
// How it works
// - mode 00 takes the field directly from the h and v sync timing.
// - mode 01 tracks the syncs but ignores field changes seen only once.
// - mode 10 runs the field on its own timer; code 11 is reserved.
// - the edge select bit picks rising (0) or falling (1) v sync edge.
// - the polarity bit says h sync is active low (0) or high (1).
// - reset clears every setting bit to zero.
// - the kind bit treats v as a v sync (0) or a frame sync (1).
// - with fix clear, the register set id toggles with the field.
// - the polarity bit also inverts both field id outputs.
module vfd_top (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // control bus register access
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // sync inputs
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  // field outputs
  output logic            field_id_expansion_out,
  output logic            field_id_vram_out,
  output logic            regset_id
);
  vfd_cfg_if cfg ();

  vfd_regs u_regs (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_data (rd_data),
    .cfg     (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sync conditioning
  logic h_act;
  logic v_q;
  logic v_arm_q;
  logic v_edge;
  assign h_act  = hsync_in ~^ cfg.hpol_high;
  // no edge until v_q holds a real sample, so no false edge after reset
  assign v_edge = v_arm_q & (cfg.vedge_fall ? (v_q & ~vsync_in) : (~v_q & vsync_in));

  ////////////////////////////////////////////////////////////////////////////
  // field state
  vfd_pkg::vfd_state_t st_q;
  vfd_pkg::vfd_state_t st_d;
  logic        field_q;
  logic        field_d;
  logic        cand_q;
  logic        cand_d;
  logic [19:0] free_q;
  logic [19:0] free_d;

  function automatic logic raw_field(input logic h_at_edge, input logic frame_kind, input logic cur);
    // frame sync marks odd field start; v sync phase against h gives parity
    raw_field = frame_kind ? 1'b1 : h_at_edge;
  endfunction

  always_comb begin
    st_d     = st_q;
    field_d  = field_q;
    cand_d   = cand_q;
    free_d   = free_q;
    case (cfg.mode)
      vfd_pkg::VFD_MODE_DIRECT: begin
        st_d = vfd_pkg::VFD_ST_TRACK;
        if (v_edge) begin
          if (cfg.vkind_frame) begin
            field_d = 1'b1;
          end else begin
            field_d = raw_field(h_act, 1'b0, field_q);
          end
        end
      end
      vfd_pkg::VFD_MODE_NOISE: begin
        st_d = vfd_pkg::VFD_ST_TRACK;
        if (v_edge) begin
          // expected alternation; accept a break only when seen twice
          if (raw_field(h_act, cfg.vkind_frame, field_q) == ~field_q || cand_q) begin
            field_d = cfg.vkind_frame ? 1'b1 : raw_field(h_act, 1'b0, field_q);
            if (raw_field(h_act, cfg.vkind_frame, field_q) == field_q && !cand_q) begin
              field_d = ~field_q;
            end
            cand_d = 1'b0;
          end else begin
            field_d = ~field_q;
            cand_d  = 1'b1;
          end
        end
      end
      vfd_pkg::VFD_MODE_FREE: begin
        st_d = vfd_pkg::VFD_ST_FREE;
        if (free_q == 20'h00000) begin
          free_d  = `VFD_FREERUN_SET;
          field_d = ~field_q;
        end else begin
          free_d = free_q - 20'h00001;
        end
      end
      default: begin
        st_d = vfd_pkg::VFD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= vfd_pkg::VFD_ST_IDLE;
      field_q  <= 1'b0;
      cand_q   <= 1'b0;
      free_q   <= `VFD_FREERUN_SET;
      v_q      <= 1'b0;
      v_arm_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      field_q  <= field_d;
      cand_q   <= cand_d;
      free_q   <= free_d;
      v_q      <= vsync_in;
      v_arm_q  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic exp_d;
  logic vram_d;
  logic rs_d;
  always_comb begin
    exp_d  = field_q ^ cfg.hpol_high;
    vram_d = field_q ^ cfg.hpol_high;
    rs_d   = (cfg.regset_fix ? 1'b1 : field_q) ^ cfg.regset_inv;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      field_id_expansion_out <= 1'b0;
      field_id_vram_out      <= 1'b0;
      regset_id              <= 1'b0;
    end else begin
      field_id_expansion_out <= exp_d;
      field_id_vram_out      <= vram_d;
      regset_id              <= rs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_direct_field: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.mode == vfd_pkg::VFD_MODE_DIRECT && v_edge && !cfg.vkind_frame) |=> field_q == $past(h_act))
    else $error("direct field mismatch");
  a_noise_once: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.mode == vfd_pkg::VFD_MODE_NOISE && v_edge && !cand_q) |=> field_q != $past(field_q))
    else $error("noise mode accepted single break");
  a_free_toggle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.mode == vfd_pkg::VFD_MODE_FREE && $past(cfg.mode) == vfd_pkg::VFD_MODE_FREE && free_q == 20'h00000)
    |=> field_q != $past(field_q))
    else $error("free run did not toggle");
  a_rsvd_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg.mode == vfd_pkg::VFD_MODE_RSVD |=> $stable(field_q))
    else $error("reserved mode moved field");
  a_edge_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!cfg.vedge_fall && $rose(vsync_in)) |-> v_edge)
    else $error("rising edge missed");
  a_edge_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.vedge_fall && $fell(vsync_in)) |-> v_edge)
    else $error("falling edge missed");
  a_hpol_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    h_act == (cfg.hpol_high ? hsync_in : ~hsync_in))
    else $error("h polarity wrong");
  a_frame_kind: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.mode == vfd_pkg::VFD_MODE_DIRECT && v_edge && cfg.vkind_frame) |=> field_q)
    else $error("frame sync not odd");
  a_regset_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!cfg.regset_fix && !cfg.regset_inv) |=> regset_id == $past(field_q))
    else $error("regset id not following");
  a_out_invert: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 field_id_vram_out == ($past(field_q) ^ $past(cfg.hpol_high)))
    else $error("field out inversion wrong");
  a_noise_accept: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.mode == vfd_pkg::VFD_MODE_NOISE && v_edge && cand_q && !cfg.vkind_frame) |=> field_q == $past(h_act))
    else $error("noise mode ignored repeated break");
  a_free_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rstn && cfg.mode == vfd_pkg::VFD_MODE_FREE && free_q != 20'h00000) |=> $stable(field_q))
    else $error("free run field moved early");
  a_free_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rstn && cfg.mode == vfd_pkg::VFD_MODE_FREE && free_q == 20'h00000) |=> free_q == `VFD_FREERUN_SET)
    else $error("free run timer not reloaded");
  a_state_track: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rstn && (cfg.mode == vfd_pkg::VFD_MODE_DIRECT || cfg.mode == vfd_pkg::VFD_MODE_NOISE))
    |=> st_q == vfd_pkg::VFD_ST_TRACK)
    else $error("state not tracking");
  a_state_free: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rstn && cfg.mode == vfd_pkg::VFD_MODE_FREE) |=> st_q == vfd_pkg::VFD_ST_FREE)
    else $error("state not free running");
  a_state_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rstn && cfg.mode == vfd_pkg::VFD_MODE_RSVD) |=> st_q == vfd_pkg::VFD_ST_IDLE)
    else $error("state not idle in reserved mode");
  a_regset_fixed: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfg.regset_fix && !cfg.regset_inv) |=> regset_id)
    else $error("regset id not fixed");
  a_regset_inv: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!cfg.regset_fix && cfg.regset_inv) |=> regset_id == !$past(field_q))
    else $error("regset id not inverted");
  a_exp_invert: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> field_id_expansion_out == ($past(field_q) ^ $past(cfg.hpol_high)))
    else $error("expansion field inversion wrong");
endmodule
`default_nettype wire

/* File: sim/vfd_sync_src.sv */
/*
  partner model: upstream decoder driving h and v sync levels.
  assumes sys_clk from the bench; levels change just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module vfd_sync_src (
  // clock
  input  wire logic sys_clk,
  // sync levels
  output logic      hsync,
  output logic      vsync
);
  initial begin
    hsync = 1'b0;
    vsync = 1'b0;
  end
  // one v edge of the given kind, h held at level h around it
  task automatic make_edge(input logic rise, input logic h);
    @(posedge sys_clk);
    hsync <= h;
    vsync <= ~rise;
    repeat (2) @(posedge sys_clk);
    vsync <= rise;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: sim/vfd_top_tb.sv */
/*
  self-checking bench of the field detection front end.
  assumes vfd_top and the sync source model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vfd_cfg.svh"
module vfd_top_tb;
  logic       sys_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic       wr_en   = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic       hs, vs, fx, fv, rid;
  logic [7:0] cfg     = 8'h00;
  int         n_errors = 0;
  int         n_checks = 0;
  int         cyc      = 0;

  always #10 sys_clk = ~sys_clk;

  vfd_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_data(rd_data), .hsync_in(hs), .vsync_in(vs), .field_id_expansion_out(fx),
    .field_id_vram_out(fv), .regset_id(rid));
  vfd_sync_src src_u (.sys_clk(sys_clk), .hsync(hs), .vsync(vs));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp1(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic cmpn(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    if (a === `VFD_REG_INIT_OFFSET) cfg = d;
  endtask
  task automatic chk(input logic f);
    cmp1(fx, f ^ cfg[`VFD_BIT_HPOL], "expansion field id");
    cmp1(fv, f ^ cfg[`VFD_BIT_HPOL], "vram field id");
    cmp1(rid, (cfg[`VFD_BIT_REGSET_FIX] | f) ^ cfg[`VFD_BIT_REGSET_INV], "register set id");
  endtask
  // reference edge with h active for odd field f, then check field ex
  task automatic vedge(input logic f, input logic ex);
    src_u.make_edge(~cfg[`VFD_BIT_VEDGE], cfg[`VFD_BIT_HPOL] ? f : ~f);
    #1;
    chk(ex);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    #1;
    cmp8(rd_data, 8'h00, "reset value");
    chk(1'b0);
    wr(8'h00, 8'ha5);
    @(posedge sys_clk);
    #1;
    cmp8(rd_data, 8'ha5, "register write");
    wr(8'h01, 8'h3c);
    @(posedge sys_clk);
    #1;
    cmp8(rd_data, 8'ha5, "unmapped write");
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    cmp8(rd_data, 8'h00, "mid-run reset");
    cfg = 8'h00;
    chk(1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  task automatic t_direct;
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {1'b0, i[2], 2'b00, i[1], i[0], 2'b00});
      vedge(1'b1, 1'b1);
      vedge(1'b0, 1'b0);
      vedge(1'b0, 1'b0);
      if (i[0]) begin
        src_u.make_edge(1'b1, cfg[`VFD_BIT_HPOL]);
        #1;
        chk(1'b0);
      end
    end
  endtask
  task automatic t_modes;
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h10);
    vedge(1'b0, 1'b1);
    wr(8'h00, 8'h20);
    vedge(1'b0, 1'b0);
    wr(8'h00, 8'h60);
    vedge(1'b0, 1'b0);
    wr(8'h00, 8'h00);
    vedge(1'b0, 1'b0);
    wr(8'h00, 8'h01);
    vedge(1'b1, 1'b1);
    vedge(1'b0, 1'b0);
    vedge(1'b1, 1'b1);
    vedge(1'b1, 1'b0);
    vedge(1'b0, 1'b0);
    wr(8'h00, 8'h00);
    vedge(1'b1, 1'b1);
    for (int m = 2; m < 4; m++) begin
      wr(8'h00, {6'h00, m[1:0]});
      vedge(1'b0, 1'b1);
      vedge(1'b1, 1'b1);
      vedge(1'b0, 1'b1);
    end
  endtask
  task automatic t_free;
    logic f0;
    int   n;
    wr(8'h00, 8'h02);
    #1;
    for (int k = 0; k < 2; k++) begin
      f0 = fx;
      n  = 0;
      while (fx === f0 && n <= `VFD_FREERUN_SET + 1) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk(~f0);
    end
    cmpn(n, `VFD_FREERUN_SET + 1, "free run period");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      results;
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs;
    t_direct;
    t_modes;
    t_free;
    results;
  end
endmodule
`default_nettype wire
